// ### src/maf_pkg.sv
// Purpose: Shared constants for the receive address filter register block
// Assumes: 32-bit AXI4-Lite register bus, 10 MHz core clock
// Notes: Register offsets are byte addresses, one aligned word each
package maf_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int NUM_MATCH = 3;
	localparam int MAC_W = 48;
	localparam int PAUSE_W = 16;
	localparam int TOP_W = 16;
	localparam int QCNT_W = 10;

	// Register byte offsets
	localparam logic [7:0] OFS_PAUSE = 8'h00;
	localparam logic [7:0] OFS_HASH_LOW = 8'h04;
	localparam logic [7:0] OFS_HASH_HIGH = 8'h08;
	localparam logic [7:0] OFS_MATCH1_LOW = 8'h0C;
	localparam logic [7:0] OFS_MATCH1_HIGH = 8'h10;
	localparam logic [7:0] OFS_MATCH2_LOW = 8'h14;
	localparam logic [7:0] OFS_MATCH2_HIGH = 8'h18;
	localparam logic [7:0] OFS_MATCH3_LOW = 8'h1C;
	localparam logic [7:0] OFS_MATCH3_HIGH = 8'h20;
	localparam logic [7:0] OFS_CTRL = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;

	// Field positions
	localparam int CTRL_SPEED100_BIT = 0;
	localparam int STAT_HIT_LSB = 0;
	localparam int STAT_PAUSE_BIT = 8;
	localparam int MCAST_BIT = 0;

	// Reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_HALF = 16'h0000;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Pause quantum timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int BIT_NS_10M = 100;
	localparam int BIT_NS_100M = 10;
	localparam int QUANTUM_BITS = 512;
	localparam logic [QCNT_W-1:0] QCYC_10M = QCNT_W'(
		(QUANTUM_BITS * BIT_NS_10M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [QCNT_W-1:0] QCYC_100M = QCNT_W'(
		(QUANTUM_BITS * BIT_NS_100M + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [QCNT_W-1:0] QCNT_ONE = QCNT_W'(1);

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] maf_merge(
		input logic [31:0] old,
		input logic [31:0] din,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < STRB_W; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = din[i*8 +: 8];
			end
		end
		return r;
	endfunction : maf_merge

endpackage : maf_pkg

// ### src/maf_pause_timer.sv
// Purpose: Pause time holder, counted down once per 512 bit times
// Assumes: speed100 is stable while a pause is running
// Notes: A load restarts the quantum so the first step is a full one
`timescale 1ns/10ps
module maf_pause_timer import maf_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic load,
	input wire logic [PAUSE_W-1:0] loadValue,
	input wire logic speed100,
	output logic [PAUSE_W-1:0] pauseTime,
	output logic pauseActive
);

	typedef struct packed {
		logic [QCNT_W-1:0] quanta;
		logic [PAUSE_W-1:0] count;
		logic active;
	} maf_timer_t;

	maf_timer_t s;
	maf_timer_t next_s;
	logic [QCNT_W-1:0] limit;

	always_comb begin
		next_s = s;
		limit = speed100 ? QCYC_100M : QCYC_10M;
		if (load) begin
			next_s.count = loadValue;
			next_s.quanta = '0;
		end else if (s.count != RST_HALF) begin
			if (s.quanta == limit - QCNT_ONE) begin
				next_s.quanta = '0;
				next_s.count = s.count - PAUSE_W'(1);
			end else begin
				next_s.quanta = s.quanta + QCNT_ONE;
			end
		end else begin
			next_s.quanta = '0;
		end
		next_s.active = (next_s.count != RST_HALF);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pauseTime = s.count;
	assign pauseActive = s.active;

endmodule : maf_pause_timer

// ### src/maf_filter_regs.sv
// Purpose: Address filter and pause time registers with AXI4-Lite access
// Assumes: Destination address arrives with first received byte in [7:0]
// Notes: Hash bit selection is done by the receive path outside this block
//
// Overview of operation
// - The pause time is held and steps down once every 512 bit times, and reads give the live value.
// - The low half of the 64-bit hash filter is read and written through the hash low word.
// - The high half of the 64-bit hash filter is read and written through the hash high word.
// - Bit 0 of each match low word marks multicast and meets the lowest bit of the first received byte.
// - Three match addresses each have a full low word and a high word using bits 15:0 only.
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module maf_filter_regs import maf_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [MAC_W-1:0] rxDestAddr,
	input wire logic rxDestValid,
	input wire logic rxPauseValid,
	input wire logic [PAUSE_W-1:0] rxPauseTime,
	output logic addrHit,
	output logic [NUM_MATCH-1:0] addrHitMask,
	output logic addrMulticast,
	output logic [2*DATA_W-1:0] hashFilter,
	output logic [PAUSE_W-1:0] pauseTime,
	output logic pauseActive
);

	typedef struct packed {
		logic awReady;
		logic wReady;
		logic awHeld;
		logic wHeld;
		logic [ADDR_W-1:0] awAddr;
		logic [DATA_W-1:0] wData;
		logic [STRB_W-1:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [DATA_W-1:0] rData;
		logic [1:0] rResp;
		logic speed100;
		logic [DATA_W-1:0] hashLow;
		logic [DATA_W-1:0] hashHigh;
		logic [NUM_MATCH-1:0][DATA_W-1:0] matchLow;
		logic [NUM_MATCH-1:0][TOP_W-1:0] matchHigh;
		logic hit;
		logic [NUM_MATCH-1:0] hitMask;
		logic multicast;
		logic [NUM_MATCH-1:0] lastHitMask;
	} maf_state_t;

	maf_state_t s;
	maf_state_t next_s;
	logic [NUM_MATCH-1:0] cmpHit;
	logic pauseLoad;
	logic [PAUSE_W-1:0] pauseLoadValue;
	logic [DATA_W-1:0] mergedPause;

	generate
		for (genvar g = 0; g < NUM_MATCH; g++) begin : gen_match
			assign cmpHit[g] = (rxDestAddr == {s.matchHigh[g], s.matchLow[g]});
		end
	endgenerate

	maf_pause_timer u_pause (
		.clk(clk),
		.rstn(rstn),
		.load(pauseLoad),
		.loadValue(pauseLoadValue),
		.speed100(s.speed100),
		.pauseTime(pauseTime),
		.pauseActive(pauseActive)
	);

	function automatic logic [DATA_W-1:0] read_word(
		input maf_state_t st,
		input logic [ADDR_W-1:0] a,
		input logic [PAUSE_W-1:0] pt,
		input logic pa,
		output logic ok);
		logic [DATA_W-1:0] d;
		d = RST_WORD;
		ok = 1'b1;
		case (a)
			OFS_PAUSE: d = {16'h0000, pt};
			OFS_HASH_LOW: d = st.hashLow;
			OFS_HASH_HIGH: d = st.hashHigh;
			OFS_MATCH1_LOW: d = st.matchLow[0];
			OFS_MATCH1_HIGH: d = {16'h0000, st.matchHigh[0]};
			OFS_MATCH2_LOW: d = st.matchLow[1];
			OFS_MATCH2_HIGH: d = {16'h0000, st.matchHigh[1]};
			OFS_MATCH3_LOW: d = st.matchLow[2];
			OFS_MATCH3_HIGH: d = {16'h0000, st.matchHigh[2]};
			OFS_CTRL: d[CTRL_SPEED100_BIT] = st.speed100;
			OFS_STATUS: begin
				d[STAT_HIT_LSB +: NUM_MATCH] = st.lastHitMask;
				d[STAT_PAUSE_BIT] = pa;
			end
			default: ok = 1'b0;
		endcase
		return d;
	endfunction : read_word

	always_comb begin
		logic rdOk;
		logic wrOk;
		logic [DATA_W-1:0] rdWord;
		logic [DATA_W-1:0] hiMerged;
		hiMerged = RST_WORD;
		rdOk = 1'b0;
		wrOk = 1'b1;
		rdWord = RST_WORD;
		next_s = s;
		pauseLoad = 1'b0;
		pauseLoadValue = rxPauseTime;
		mergedPause = maf_merge({16'h0000, pauseTime}, s.wData, s.wStrb);

		// Address and data are taken independently, in either order
		if (s.awReady && s_axi_awvalid) begin
			next_s.awHeld = 1'b1;
			next_s.awAddr = s_axi_awaddr;
		end
		if (s.wReady && s_axi_wvalid) begin
			next_s.wHeld = 1'b1;
			next_s.wData = s_axi_wdata;
			next_s.wStrb = s_axi_wstrb;
		end
		if (s.bValid && s_axi_bready) begin
			next_s.bValid = 1'b0;
		end

		if (s.awHeld && s.wHeld) begin
			next_s.awHeld = 1'b0;
			next_s.wHeld = 1'b0;
			next_s.bValid = 1'b1;
			case (s.awAddr)
				OFS_PAUSE: begin
					pauseLoad = 1'b1;
					pauseLoadValue = mergedPause[PAUSE_W-1:0];
				end
				OFS_HASH_LOW: next_s.hashLow =
					maf_merge(s.hashLow, s.wData, s.wStrb);
				OFS_HASH_HIGH: next_s.hashHigh =
					maf_merge(s.hashHigh, s.wData, s.wStrb);
				OFS_MATCH1_LOW: next_s.matchLow[0] =
					maf_merge(s.matchLow[0], s.wData, s.wStrb);
				OFS_MATCH1_HIGH: begin
					hiMerged = maf_merge({16'h0000, s.matchHigh[0]},
						s.wData, s.wStrb);
					next_s.matchHigh[0] = hiMerged[TOP_W-1:0];
				end
				OFS_MATCH2_LOW: next_s.matchLow[1] =
					maf_merge(s.matchLow[1], s.wData, s.wStrb);
				OFS_MATCH2_HIGH: begin
					hiMerged = maf_merge({16'h0000, s.matchHigh[1]},
						s.wData, s.wStrb);
					next_s.matchHigh[1] = hiMerged[TOP_W-1:0];
				end
				OFS_MATCH3_LOW: next_s.matchLow[2] =
					maf_merge(s.matchLow[2], s.wData, s.wStrb);
				OFS_MATCH3_HIGH: begin
					hiMerged = maf_merge({16'h0000, s.matchHigh[2]},
						s.wData, s.wStrb);
					next_s.matchHigh[2] = hiMerged[TOP_W-1:0];
				end
				OFS_CTRL: begin
					if (s.wStrb[0]) begin
						next_s.speed100 = s.wData[CTRL_SPEED100_BIT];
					end
				end
				default: wrOk = 1'b0;
			endcase
			next_s.bResp = wrOk ? RESP_OKAY : RESP_SLVERR;
		end

		// Software write wins over a pause frame in the same cycle
		if (!pauseLoad && rxPauseValid) begin
			pauseLoad = 1'b1;
			pauseLoadValue = rxPauseTime;
		end

		// Accept no new write until the response has gone
		next_s.awReady = !next_s.awHeld && !next_s.bValid;
		next_s.wReady = !next_s.wHeld && !next_s.bValid;

		if (s.rValid && s_axi_rready) begin
			next_s.rValid = 1'b0;
		end
		if (s.arReady && s_axi_arvalid) begin
			rdWord = read_word(s, s_axi_araddr, pauseTime, pauseActive,
				rdOk);
			next_s.rValid = 1'b1;
			next_s.rData = rdWord;
			next_s.rResp = rdOk ? RESP_OKAY : RESP_SLVERR;
		end
		next_s.arReady = !next_s.rValid;

		next_s.hit = rxDestValid && (cmpHit != '0);
		next_s.hitMask = rxDestValid ? cmpHit : '0;
		next_s.multicast = rxDestValid && rxDestAddr[MCAST_BIT];
		if (rxDestValid) begin
			next_s.lastHitMask = cmpHit;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awReady;
	assign s_axi_wready = s.wReady;
	assign s_axi_bvalid = s.bValid;
	assign s_axi_bresp = s.bResp;
	assign s_axi_arready = s.arReady;
	assign s_axi_rvalid = s.rValid;
	assign s_axi_rdata = s.rData;
	assign s_axi_rresp = s.rResp;
	assign addrHit = s.hit;
	assign addrHitMask = s.hitMask;
	assign addrMulticast = s.multicast;
	assign hashFilter = {s.hashHigh, s.hashLow};

endmodule : maf_filter_regs

// ### bench/maf_filter_assertions.sv
// Purpose: Port-level checks for the filter register block
// Assumes: One clock, async active-low reset
// Notes: Bound to the top module from the bench
`timescale 1ns/10ps
module maf_filter_assertions import maf_pkg::*; (
	input wire logic clk,
	input wire logic rstn,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic [MAC_W-1:0] rxDestAddr,
	input wire logic rxDestValid,
	input wire logic rxPauseValid,
	input wire logic [PAUSE_W-1:0] rxPauseTime,
	input wire logic addrHit,
	input wire logic [NUM_MATCH-1:0] addrHitMask,
	input wire logic addrMulticast,
	input wire logic [2*DATA_W-1:0] hashFilter,
	input wire logic [PAUSE_W-1:0] pauseTime,
	input wire logic pauseActive
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	hit_mask_a: assert property (addrHit == (addrHitMask != 3'h0))
		else $error("hit flag and mask disagree");
	hit_cause_a: assert property (!rxDestValid |=> !addrHit)
		else $error("hit without a destination");
	mcast_bit_a: assert property (rxDestValid |=>
		addrMulticast == $past(rxDestAddr[0]))
		else $error("multicast flag wrong");
	// Idle awready means no bus write lands on this edge
	pause_load_a: assert property (rxPauseValid && s_axi_awready |=>
		pauseTime == $past(rxPauseTime))
		else $error("pause load lost");
	pause_step_a: assert property (!rxPauseValid && s_axi_awready &&
		pauseActive |=> pauseTime == $past(pauseTime) ||
		pauseTime == $past(pauseTime) - 16'h1)
		else $error("pause moved by more than one");
	pause_stop_a: assert property (!rxPauseValid && s_axi_awready &&
		!pauseActive |=> pauseTime == 16'h0)
		else $error("pause left zero");
	pause_flag_a: assert property (pauseActive == (pauseTime != 16'h0))
		else $error("pause flag wrong");
	hash_write_a: assert property ($changed(hashFilter) |->
		$rose(s_axi_bvalid))
		else $error("hash changed without write");
	cover property (addrHit);
	cover property ($fell(pauseActive));
	cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : maf_filter_assertions

// ### bench/maf_rx_model.sv
// Purpose: Receive path model giving destinations and pause loads
// Assumes: Called from the bench with a gap of one or more cycles
// Notes: Released address shows its inverse so stale data never matches
`timescale 1ns/10ps
module maf_rx_model import maf_pkg::*; (
	input wire logic clk,
	output logic [MAC_W-1:0] rxDestAddr,
	output logic rxDestValid,
	output logic rxPauseValid,
	output logic [PAUSE_W-1:0] rxPauseTime
);
	initial begin
		rxDestAddr = 48'h0;
		rxDestValid = 1'h0;
		rxPauseValid = 1'h0;
		rxPauseTime = 16'h0;
	end
	task automatic send_dest(input logic [MAC_W-1:0] a, input int gap);
		repeat (gap) @(posedge clk);
		rxDestAddr <= a;
		rxDestValid <= 1'h1;
		@(posedge clk);
		rxDestValid <= 1'h0;
		rxDestAddr <= ~a;
	endtask : send_dest
	task automatic send_pause(input logic [PAUSE_W-1:0] t, input int gap);
		repeat (gap) @(posedge clk);
		rxPauseTime <= t;
		rxPauseValid <= 1'h1;
		@(posedge clk);
		rxPauseValid <= 1'h0;
		rxPauseTime <= ~t;
	endtask : send_pause
endmodule : maf_rx_model

// ### bench/tb_maf_filter_regs.sv
// Purpose: Self-checking bench for the filter register block
// Assumes: CTRL speed bit set by the table, so quanta are 52 cycles
// Notes: Table loop first, then destination matches, refusals, pause and a second reset
`timescale 1ns/10ps
module tb_maf_filter_regs import maf_pkg::*;;
	logic clk = 1'h0, rstn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [ADDR_W-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [STRB_W-1:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, addrHit, addrMulticast, pauseActive, rxDestValid;
	logic rxPauseValid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [NUM_MATCH-1:0] addrHitMask;
	logic [2*DATA_W-1:0] hashFilter;
	logic [PAUSE_W-1:0] pauseTime, rxPauseTime;
	logic [MAC_W-1:0] rxDestAddr;
	int failures = 0, testsRun = 0, cycles = 0;
	localparam logic [7:0] RA [9] = '{OFS_HASH_LOW, OFS_HASH_HIGH,
		OFS_MATCH1_LOW, OFS_MATCH1_HIGH, OFS_MATCH2_LOW, OFS_MATCH2_HIGH,
		OFS_MATCH3_LOW, OFS_MATCH3_HIGH, OFS_CTRL};
	localparam logic [31:0] RD [9] = '{32'hA5A5_0F0F, 32'h8000_0001,
		32'h4433_2210, 32'hFFFF_6655, 32'hCCBB_AA01, 32'h0000_EEDD,
		32'h1234_5678, 32'h5A5A_9ABC, 32'h0000_0001};
	// Match high words keep bits 15:0 only
	localparam logic [31:0] RE [9] = '{32'hA5A5_0F0F, 32'h8000_0001,
		32'h4433_2210, 32'h0000_6655, 32'hCCBB_AA01, 32'h0000_EEDD,
		32'h1234_5678, 32'h0000_9ABC, 32'h0000_0001};
	// Destination, expected mask, expected multicast; last is a near miss
	localparam logic [51:0] RX [3] = '{{48'h6655_4433_2210, 4'h2},
		{48'hEEDD_CCBB_AA01, 4'h5}, {48'h6656_4433_2210, 4'h0}};
	maf_filter_regs dut (.*);
	maf_rx_model rx (.*);
	initial forever #50 clk = ~clk;
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		testsRun++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic axw(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] resp);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && s_axi_awready) begin
				aw = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (!w && s_axi_wready) begin
				w = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		while (s_axi_bvalid !== 1'h1) @(posedge clk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] resp);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		while (s_axi_rvalid !== 1'h1) @(posedge clk);
		v = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : axr
	task automatic tally_and_finish;
		$display("failures=%0d testsRun=%0d", failures, testsRun);
		if (failures == 0 && testsRun > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'h1;
		for (int i = 0; i < 9; i++) begin
			axr(RA[i], d, r);
			chk(d, 32'h0);
			axw(RA[i], RD[i], r);
			chk(r, RESP_OKAY);
			axr(RA[i], d, r);
			chk(d, RE[i]);
		end
		chk(hashFilter, {RD[1], RD[0]});
		for (int i = 0; i < 3; i++) begin
			rx.send_dest(RX[i][51:4], 2);
			#1;
			chk(addrHitMask, RX[i][3:1]);
			chk(addrMulticast, RX[i][0]);
			chk(addrHit, RX[i][3:1] != 3'h0);
		end
		axr(OFS_STATUS, d, r);
		chk(d, 32'h0);
		axr(8'h2C, d, r);
		chk({r, d}, {RESP_SLVERR, 32'h0});
		axw(OFS_STATUS, 32'hFFFF_FFFF, r);
		chk(r, RESP_SLVERR);
		axw(8'h05, 32'h0000_0001, r);
		chk(r, RESP_SLVERR);
		axr(OFS_HASH_LOW, d, r);
		chk(d, RD[0]);
		rx.send_pause(16'h0003, 1);
		#1;
		chk(pauseTime, 16'h0003);
		repeat (51) @(posedge clk);
		#1;
		chk(pauseTime, 16'h0003);
		@(posedge clk);
		#1;
		chk(pauseTime, 16'h0002);
		axr(OFS_PAUSE, d, r);
		chk(d, 32'h2);
		axw(OFS_PAUSE, 32'hFFFF_0001, r);
		repeat (50) @(posedge clk);
		#1;
		chk(pauseTime, 16'h0001);
		repeat (2) @(posedge clk);
		#1;
		chk({pauseActive, pauseTime}, 17'h0);
		@(posedge clk);
		rstn <= 1'h0;
		repeat (3) @(posedge clk);
		rstn <= 1'h1;
		axr(OFS_MATCH2_LOW, d, r);
		chk({d, hashFilter}, 96'h0);
		tally_and_finish();
	end
endmodule : tb_maf_filter_regs
bind maf_filter_regs maf_filter_assertions chk_i (.clk, .rstn,
	.s_axi_awready, .s_axi_bvalid, .s_axi_bresp, .rxDestAddr, .rxDestValid,
	.rxPauseValid, .rxPauseTime, .addrHit, .addrHitMask, .addrMulticast,
	.hashFilter, .pauseTime, .pauseActive);
